/* design/sfot_pkg.sv */
// constants for the sync filter and output timing block
// assumes one pixel-rate clock and a plain register port with 8-bit addresses
package sfot_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_FILTER = 8'h21;
   localparam logic [7:0] ADDR_VDUR = 8'h22;
   localparam logic [7:0] ADDR_HWIDTH = 8'h23;
   localparam logic [7:0] ADDR_POL = 8'h24;
   localparam logic [7:0] ADDR_CLKMODE = 8'h25;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_FILTER = 8'hCC;
   localparam logic [7:0] RST_VDUR = 8'h04;
   localparam logic [7:0] RST_HWIDTH = 8'h20;
   localparam logic [7:0] RST_POL = 8'hFE;
   localparam logic [7:0] RST_CLKMODE = 8'h70;
   localparam logic [7:0] CLKMODE_MASK = 8'hFC; // low two bits read as zero
   // ==========================================================
   // field positions
   localparam int B_SP_FILT = 7;
   localparam int B_PLL_FILT = 6;
   localparam int B_VFILT = 5;
   localparam int B_VDUR = 4;
   localparam int B_OFS_MODE = 3;
   localparam int B_OFS_LEN = 2;
   localparam int B_HS_POL = 7;
   localparam int B_VS_POL = 6;
   localparam int B_DE_POL = 5;
   localparam int B_FLD_POL = 4;
   localparam int B_SOG_POL = 3;
   localparam int B_SOG_SEL = 1;
   localparam int B_CLK_INV = 0;
   localparam int B_CLK_SEL = 6;
   localparam int B_OMODE = 2;
   // ==========================================================
   // timing counts in pixel clocks
   localparam logic [4:0] OFS_DELAY_SHORT = 5'h0A;
   localparam logic [4:0] OFS_DELAY_LONG = 5'h10;
   localparam logic [4:0] OFS_SAMPLE_LEN = 5'h06;
   // ==========================================================
   // selector codes
   localparam logic [1:0] SOG_SEL_GREEN = 2'h0;
   localparam logic [1:0] SOG_SEL_RAW = 2'h1;
   localparam logic [1:0] SOG_SEL_REGEN = 2'h2;
   localparam logic [1:0] SOG_SEL_PLL = 2'h3;
   localparam logic [1:0] CLK_SEL_HALF = 2'h0;
   localparam logic [1:0] CLK_SEL_1X = 2'h1;
   localparam logic [1:0] CLK_SEL_2X = 2'h2;
   localparam logic [1:0] CLK_SEL_90 = 2'h3;
   localparam logic [1:0] OMODE_444 = 2'h0;
   localparam logic [1:0] OMODE_422 = 2'h1;
   localparam logic [1:0] OMODE_DDR444 = 2'h2;
   typedef enum logic [1:0] {OFS_IDLE, OFS_WAIT, OFS_SAMPLE} sfot_ofs_state_t;
endpackage

/* design/sfot_hsync_gen.sv */
// output hsync pulse generator: fixed width pulse per trigger
// assumes trigger is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module sfot_hsync_gen (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic trig_in,
   input wire logic [7:0] width_in,
   output logic active_out
);
   typedef struct packed {
      logic active;
      logic [7:0] cnt;
   } sfot_hg_state_t;
   sfot_hg_state_t s_q, s_d;

   // ==========================================================
   // pulse counter; a trigger inside a running pulse is ignored
   always_comb begin
      s_d = s_q;
      if (!s_q.active) begin
         if (trig_in && (width_in != 8'h00)) begin
            s_d.active = 1'b1;
            s_d.cnt = width_in;
         end
      end else if (s_q.cnt <= 8'h01) begin
         s_d.active = 1'b0;
         s_d.cnt = 8'h00;
      end else begin
         s_d.cnt = s_q.cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign active_out = s_q.active;

   a_hs_width: assert property (@(posedge clk_in) disable iff (srst_in)
      (trig_in && !s_q.active && width_in == 8'h05) |=> s_q.active[*5] ##1 !s_q.active)
      else $error("hsync pulse width wrong");
endmodule // sfot_hsync_gen
`default_nettype wire

/* design/sfot_top.sv */
// sync filtering and output formatting for a dual-path video receiver
// assumes pins are asynchronous, other sync sources come from on-chip logic
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sfot_top (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic horizontal_sync_in_a,
   input wire logic horizontal_sync_in_b,
   input wire logic green_channel_sync_in_a,
   input wire logic green_channel_sync_in_b,
   input wire logic input_sel_in,
   input wire logic digital_path_in,
   input wire logic hsync_filtered_in,
   input wire logic hsync_regen_in,
   input wire logic vsync_in,
   input wire logic de_in,
   input wire logic field_in,
   input wire logic clamp_in,
   input wire logic [1:0] pix_rep_in,
   input wire logic [23:0] pixel_in,
   output logic pll_hsync_out,
   output logic coast_hsync_out,
   output logic hsync_out,
   output logic vsync_out,
   output logic de_out,
   output logic field_out,
   output logic green_channel_sync_out,
   output logic offset_sample_out,
   output logic clk_out,
   output logic [23:0] data_out,
   output logic [7:0] blue_ddr_out
);
   typedef struct packed {
      logic [7:0] r_filt;
      logic [7:0] r_vdur;
      logic [7:0] r_hwid;
      logic [7:0] r_pol;
      logic [7:0] r_clk;
      logic [7:0] rdata;
      logic [3:0] pin_m;
      logic [3:0] pin_s;
      logic sp_prev;
      logic pll_prev;
      logic [1:0] vf_cnt;
      logic vf;
      logic vsel_prev;
      logic vd_act;
      logic [7:0] vd_cnt;
      sfot_pkg::sfot_ofs_state_t ofs_st;
      logic [4:0] ofs_cnt;
      logic clamp_prev;
      logic ofs_sample;
      logic [1:0] rep_cnt;
      logic [2:0] ph;
      logic clk_o;
      logic pll_hs;
      logic coast_hs;
      logic hs_o;
      logic vs_o;
      logic de_o;
      logic fld_o;
      logic sog_o;
      logic c_sel;
      logic [23:0] dat_o;
      logic [7:0] blue_o;
   } sfot_state_t;
   sfot_state_t s_q, s_d;

   logic hs_act;
   logic raw_hs;
   logic sog_in;
   logic sp_hs;
   logic pll_src;
   logic sp_edge;
   logic pll_edge;
   logic vsel;
   logic v_act;
   logic sog_act;
   logic clk_raw;
   logic ce_1x;

   // applies an active-high level to a pin of chosen polarity
   function automatic logic sfot_pol(input logic act, input logic pol);
      sfot_pol = pol ? act : ~act;
   endfunction

   // ==========================================================
   // hsync output pulse, triggered on the PLL hsync leading edge
   sfot_hsync_gen u_hsync_gen (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .trig_in(pll_edge),
      .width_in(s_q.r_hwid),
      .active_out(hs_act)
   );

   // ==========================================================
   // source selection; the pin sources are read straight from the second sync stage, the on-chip sources directly
   always_comb begin
      raw_hs = input_sel_in ? s_q.pin_s[1] : s_q.pin_s[0];
      sog_in = input_sel_in ? s_q.pin_s[3] : s_q.pin_s[2];
      sp_hs = s_q.r_filt[sfot_pkg::B_SP_FILT] ? hsync_regen_in : raw_hs;
      pll_src = s_q.r_filt[sfot_pkg::B_PLL_FILT] ? hsync_filtered_in : raw_hs;
      sp_edge = sp_hs && !s_q.sp_prev;
      pll_edge = pll_src && !s_q.pll_prev;
      vsel = s_q.r_filt[sfot_pkg::B_VFILT] ? s_q.vf : vsync_in;
      v_act = s_q.r_filt[sfot_pkg::B_VDUR] ? s_q.vd_act : vsel;
      unique case (s_q.r_pol[sfot_pkg::B_SOG_SEL +: 2])
         sfot_pkg::SOG_SEL_GREEN: sog_act = sog_in;
         sfot_pkg::SOG_SEL_RAW: sog_act = raw_hs;
         sfot_pkg::SOG_SEL_REGEN: sog_act = hsync_regen_in;
         sfot_pkg::SOG_SEL_PLL: sog_act = pll_src;
      endcase
      unique case (s_q.r_clk[sfot_pkg::B_CLK_SEL +: 2])
         sfot_pkg::CLK_SEL_HALF: clk_raw = s_q.ph[2];
         sfot_pkg::CLK_SEL_1X: clk_raw = s_q.ph[1];
         sfot_pkg::CLK_SEL_2X: clk_raw = s_q.ph[0];
         sfot_pkg::CLK_SEL_90: clk_raw = s_q.ph[1] ^ s_q.ph[0];
      endcase
      ce_1x = (s_q.rep_cnt == pix_rep_in);
   end

   // ==========================================================
   // next-state logic for the whole block
   always_comb begin
      s_d = s_q;
      // register writes; every bit is kept except the two low bits of the clock mode register
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            sfot_pkg::ADDR_FILTER: s_d.r_filt = reg_wdata_in;
            sfot_pkg::ADDR_VDUR: s_d.r_vdur = reg_wdata_in;
            sfot_pkg::ADDR_HWIDTH: s_d.r_hwid = reg_wdata_in;
            sfot_pkg::ADDR_POL: s_d.r_pol = reg_wdata_in;
            sfot_pkg::ADDR_CLKMODE: s_d.r_clk = reg_wdata_in & sfot_pkg::CLKMODE_MASK;
            default: s_d.rdata = s_q.rdata;
         endcase
      end
      // read data stands one cycle after the strobe only
      s_d.rdata = 8'h00;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            sfot_pkg::ADDR_FILTER: s_d.rdata = s_q.r_filt;
            sfot_pkg::ADDR_VDUR: s_d.rdata = s_q.r_vdur;
            sfot_pkg::ADDR_HWIDTH: s_d.rdata = s_q.r_hwid;
            sfot_pkg::ADDR_POL: s_d.rdata = s_q.r_pol;
            sfot_pkg::ADDR_CLKMODE: s_d.rdata = s_q.r_clk;
            default: s_d.rdata = 8'h00;
         endcase
      end
      // two-stage synchronisers for the sync pins
      s_d.pin_m = {green_channel_sync_in_b, green_channel_sync_in_a,
                   horizontal_sync_in_b, horizontal_sync_in_a};
      s_d.pin_s = s_q.pin_m;
      s_d.sp_prev = sp_hs;
      s_d.pll_prev = pll_src;
      s_d.pll_hs = pll_src;
      s_d.coast_hs = sp_hs;

      // vsync filter: open on the second hsync edge inside vsync,
      // close on the first hsync edge after it, so timing is fixed
      if (!vsync_in) begin
         s_d.vf_cnt = 2'h0;
         if (sp_edge) begin
            s_d.vf = 1'b0;
         end
      end else if (sp_edge) begin
         if (s_q.vf_cnt == 2'h1) begin
            s_d.vf = 1'b1;
         end
         if (s_q.vf_cnt != 2'h2) begin
            s_d.vf_cnt = s_q.vf_cnt + 2'h1;
         end
      end

      // duration block: a fresh vsync start runs for r_vdur lines
      s_d.vsel_prev = vsel;
      if (vsel && !s_q.vsel_prev && (s_q.r_vdur != 8'h00)) begin
         s_d.vd_act = 1'b1;
         s_d.vd_cnt = s_q.r_vdur;
      end else if (s_q.vd_act && sp_edge) begin
         if (s_q.vd_cnt <= 8'h01) begin
            s_d.vd_act = 1'b0;
            s_d.vd_cnt = 8'h00;
         end else begin
            s_d.vd_cnt = s_q.vd_cnt - 8'h01;
         end
      end

      // auto-offset sample window
      s_d.clamp_prev = clamp_in;
      if (!s_q.r_filt[sfot_pkg::B_OFS_MODE]) begin
         s_d.ofs_st = sfot_pkg::OFS_IDLE;
         s_d.ofs_cnt = 5'h00;
         s_d.ofs_sample = clamp_in;
      end else begin
         unique case (s_q.ofs_st)
            sfot_pkg::OFS_IDLE: begin
               s_d.ofs_sample = 1'b0;
               if (s_q.clamp_prev && !clamp_in) begin
                  s_d.ofs_st = sfot_pkg::OFS_WAIT;
                  s_d.ofs_cnt = 5'h00;
               end
            end
            sfot_pkg::OFS_WAIT: begin
               s_d.ofs_cnt = s_q.ofs_cnt + 5'h01;
               // delay counted from the end of clamp
               if (s_q.ofs_cnt == (s_q.r_filt[sfot_pkg::B_OFS_LEN] ?
                     sfot_pkg::OFS_DELAY_LONG : sfot_pkg::OFS_DELAY_SHORT) - 5'h01) begin
                  s_d.ofs_st = sfot_pkg::OFS_SAMPLE;
                  s_d.ofs_cnt = 5'h00;
                  s_d.ofs_sample = 1'b1;
               end
            end
            sfot_pkg::OFS_SAMPLE: begin
               s_d.ofs_cnt = s_q.ofs_cnt + 5'h01;
               if (s_q.ofs_cnt == sfot_pkg::OFS_SAMPLE_LEN - 5'h01) begin
                  s_d.ofs_st = sfot_pkg::OFS_IDLE;
                  s_d.ofs_cnt = 5'h00;
                  s_d.ofs_sample = 1'b0;
               end
            end
            default: begin
               s_d.ofs_st = sfot_pkg::OFS_IDLE;
               s_d.ofs_sample = 1'b0;
            end
         endcase
      end

      // output clock: repetition divider gives the 1x enable,
      // a phase counter makes the derived rates
      if (ce_1x) begin
         s_d.rep_cnt = 2'h0;
         s_d.ph = s_q.ph + 3'h1;
      end else begin
         s_d.rep_cnt = s_q.rep_cnt + 2'h1;
      end
      s_d.clk_o = clk_raw ^ s_q.r_pol[sfot_pkg::B_CLK_INV];

      // polarity of the sync outputs
      s_d.hs_o = sfot_pol(hs_act, s_q.r_pol[sfot_pkg::B_HS_POL]);
      s_d.vs_o = sfot_pol(v_act, s_q.r_pol[sfot_pkg::B_VS_POL]);
      s_d.de_o = sfot_pol(de_in, s_q.r_pol[sfot_pkg::B_DE_POL]);
      s_d.fld_o = sfot_pol(field_in, s_q.r_pol[sfot_pkg::B_FLD_POL]);
      // digital path leaves the green sync pin active high
      s_d.sog_o = digital_path_in ? sog_act :
                  sfot_pol(sog_act, s_q.r_pol[sfot_pkg::B_SOG_POL]);

      // pin mode; pixel is {Cr, Y, Cb}, chroma alternates per pixel
      s_d.c_sel = ~s_q.c_sel;
      unique case (s_q.r_clk[sfot_pkg::B_OMODE +: 2])
         sfot_pkg::OMODE_422: begin
            s_d.dat_o = {pixel_in[15:8], s_q.c_sel ? pixel_in[23:16] : pixel_in[7:0], 8'h00};
            s_d.blue_o = s_q.ph[0] ? pixel_in[15:8] : s_d.dat_o[15:8];
         end
         sfot_pkg::OMODE_DDR444: begin
            s_d.dat_o = {s_q.ph[0] ? pixel_in[23:12] : pixel_in[11:0], 12'h000};
            s_d.blue_o = s_q.ph[0] ? pixel_in[15:8] :
                         (s_q.c_sel ? pixel_in[23:16] : pixel_in[7:0]);
         end
         default: begin
            // code 11 is not a pixel mode here, treated as normal
            s_d.dat_o = pixel_in;
            s_d.blue_o = 8'h00;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_q <= '0;
         s_q.r_filt <= sfot_pkg::RST_FILTER;
         s_q.r_vdur <= sfot_pkg::RST_VDUR;
         s_q.r_hwid <= sfot_pkg::RST_HWIDTH;
         s_q.r_pol <= sfot_pkg::RST_POL;
         s_q.r_clk <= sfot_pkg::RST_CLKMODE;
         s_q.ofs_st <= sfot_pkg::OFS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   assign reg_rdata_out = s_q.rdata;
   assign pll_hsync_out = s_q.pll_hs;
   assign coast_hsync_out = s_q.coast_hs;
   assign hsync_out = s_q.hs_o;
   assign vsync_out = s_q.vs_o;
   assign de_out = s_q.de_o;
   assign field_out = s_q.fld_o;
   assign green_channel_sync_out = s_q.sog_o;
   assign offset_sample_out = s_q.ofs_sample;
   assign clk_out = s_q.clk_o;
   assign data_out = s_q.dat_o;
   assign blue_ddr_out = s_q.blue_o;

   // ==========================================================
   // checks
   a_pll_source: assert property (@(posedge clk_in) disable iff (srst_in)
      s_q.r_filt[sfot_pkg::B_PLL_FILT] && !reg_wr_in |=> pll_hsync_out == $past(hsync_filtered_in))
      else $error("pll hsync not from filtered source");
   a_vfilt_start: assert property (@(posedge clk_in) disable iff (srst_in)
      $rose(s_q.vf) |-> $past(sp_edge) && $past(s_q.vf_cnt) == 2'h1)
      else $error("vsync filter opened off the second edge");
   a_vdur_start: assert property (@(posedge clk_in) disable iff (srst_in)
      (vsel && !s_q.vsel_prev && s_q.r_vdur == 8'h02) |=> s_q.vd_act && s_q.vd_cnt == 8'h02)
      else $error("duration block did not start");
   a_ofs_clamp: assert property (@(posedge clk_in) disable iff (srst_in)
      !s_q.r_filt[sfot_pkg::B_OFS_MODE] && !reg_wr_in |=> offset_sample_out == $past(clamp_in))
      else $error("sample does not follow clamp");
   a_ofs_short: assert property (@(posedge clk_in) disable iff (srst_in)
      (s_q.clamp_prev && !clamp_in && s_q.ofs_st == sfot_pkg::OFS_IDLE && !reg_wr_in
       && s_q.r_filt[sfot_pkg::B_OFS_MODE] && !s_q.r_filt[sfot_pkg::B_OFS_LEN])
      |-> ##10 !offset_sample_out ##1 offset_sample_out[*6] ##1 !offset_sample_out)
      else $error("short post-clamp window wrong");
   a_ofs_long: assert property (@(posedge clk_in) disable iff (srst_in)
      (s_q.clamp_prev && !clamp_in && s_q.ofs_st == sfot_pkg::OFS_IDLE && !reg_wr_in
       && s_q.r_filt[sfot_pkg::B_OFS_MODE] && s_q.r_filt[sfot_pkg::B_OFS_LEN])
      |-> ##16 !offset_sample_out ##1 offset_sample_out[*6] ##1 !offset_sample_out)
      else $error("long post-clamp window wrong");
   a_hs_polarity: assert property (@(posedge clk_in) disable iff (srst_in)
      !reg_wr_in |=> hsync_out == ($past(hs_act) ~^ $past(s_q.r_pol[sfot_pkg::B_HS_POL])))
      else $error("hsync polarity wrong");
   a_sog_select: assert property (@(posedge clk_in) disable iff (srst_in)
      (s_q.r_pol[2:1] == sfot_pkg::SOG_SEL_REGEN && s_q.r_pol[sfot_pkg::B_SOG_POL] && !reg_wr_in)
      |=> green_channel_sync_out == $past(hsync_regen_in))
      else $error("green sync source wrong");
   a_pix_normal: assert property (@(posedge clk_in) disable iff (srst_in)
      (s_q.r_clk[3:2] == sfot_pkg::OMODE_444 && !reg_wr_in) |=> data_out == $past(pixel_in))
      else $error("normal mode data wrong");
endmodule // sfot_top
`default_nettype wire

/* test/sfot_sink.sv */
// downstream sink model: measures output hsync width and output clock pin toggles
// assumes it shares the pixel clock with the block and is told the hsync polarity
`timescale 1ns/1ps
`default_nettype none
module sfot_sink (
   input wire logic clk_in,
   input wire logic clr_in,
   input wire logic hsync_in,
   input wire logic hs_active_high_in,
   input wire logic clk_pin_in,
   output logic [8:0] hs_width_out,
   output logic [7:0] clk_edges_out
);
   // ==========================================================
   // measurement
   logic [8:0] run_q;
   logic clk_pin_q;
   // active is judged by the level the receiver expects, so a polarity slip shows as a width error
   always_ff @(posedge clk_in) begin
      clk_pin_q <= clk_pin_in;
      if (clr_in) begin
         run_q <= 9'h000;
         hs_width_out <= 9'h000;
         clk_edges_out <= 8'h00;
      end else begin
         if (clk_pin_in != clk_pin_q) clk_edges_out <= clk_edges_out + 8'h01;
         if (hsync_in == hs_active_high_in) run_q <= run_q + 9'h001;
         else if (run_q != 9'h000) begin
            hs_width_out <= run_q; // width latched when the pulse ends
            run_q <= 9'h000;
         end
      end
   end
endmodule // sfot_sink
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the sync filter and output timing block
// assumes one 10 MHz clock; sources and pins are driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ==========================================================
   // stimulus and wiring
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic wr = 1'b0, rd = 1'b0, hs_a = 1'b0, sog_a = 1'b0, hfilt = 1'b0, hregen = 1'b0;
   logic vs = 1'b0, de = 1'b0, fld = 1'b0, clamp = 1'b0, clr = 1'b0, hpol = 1'b1, dig = 1'b0;
   logic [1:0] prep = 2'h0;
   logic [23:0] pix = 24'h000000;
   wire logic [7:0] rdat, blue, ce;
   wire logic [23:0] dout;
   wire logic [8:0] hw;
   wire logic pll_hs, coast, hs, vso, deo, fo, sogo, smp, cko;
   int bad_count = 0;
   int checked = 0;
   sfot_top i_dut (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdat),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .horizontal_sync_in_a(hs_a),
      .horizontal_sync_in_b(1'b0), .green_channel_sync_in_a(sog_a),
      .green_channel_sync_in_b(1'b0), .input_sel_in(1'b0), .digital_path_in(dig),
      .hsync_filtered_in(hfilt), .hsync_regen_in(hregen), .vsync_in(vs), .de_in(de),
      .field_in(fld), .clamp_in(clamp), .pix_rep_in(prep), .pixel_in(pix),
      .pll_hsync_out(pll_hs), .coast_hsync_out(coast), .hsync_out(hs), .vsync_out(vso),
      .de_out(deo), .field_out(fo), .green_channel_sync_out(sogo), .offset_sample_out(smp),
      .clk_out(cko), .data_out(dout), .blue_ddr_out(blue));
   sfot_sink i_sink (.clk_in(clk_in), .clr_in(clr), .hsync_in(hs), .hs_active_high_in(hpol),
      .clk_pin_in(cko), .hs_width_out(hw), .clk_edges_out(ce));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   // ==========================================================
   // shared tasks
   task automatic stop_test;
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk("reg_rdata", {16'h0000, rdat}, {16'h0000, exp});
   endtask
   // one rising edge on the pll source, then the width seen by the sink
   task automatic pulse_hs(input logic [8:0] exp);
      @(posedge clk_in);
      clr <= 1'b1;
      hfilt <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      @(posedge clk_in);
      hfilt <= 1'b0;
      cyc(45);
      #1;
      chk("hsync_width", {15'h0000, hw}, {15'h0000, exp});
      chk("hsync_idle", hs, !hpol);
   endtask
   // clamp for three cycles, then count sample cycles and note the first
   task automatic ofs_run(input logic [7:0] r21, output int first, output int n);
      wr_reg(sfot_pkg::ADDR_FILTER, r21);
      @(posedge clk_in);
      clamp <= 1'b1;
      first = 0;
      n = 0;
      for (int i = 1; i <= 45; i++) begin
         @(posedge clk_in);
         if (i == 3) clamp <= 1'b0;
         #1;
         if (smp === 1'b1) begin
            if (first == 0) first = i;
            n++;
         end
      end
   endtask
   task automatic clk_run(input logic [1:0] sel, input logic [7:0] exp);
      wr_reg(sfot_pkg::ADDR_CLKMODE, {sel, 6'h30});
      cyc(8);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      cyc(16);
      #1;
      chk("clk_toggles", {16'h0000, ce}, {16'h0000, exp});
   endtask
   task automatic hr_pulse;
      @(posedge clk_in);
      hregen <= 1'b1;
      @(posedge clk_in);
      hregen <= 1'b0;
      cyc(4);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      rd_reg(sfot_pkg::ADDR_FILTER, sfot_pkg::RST_FILTER);
      rd_reg(sfot_pkg::ADDR_VDUR, sfot_pkg::RST_VDUR);
      rd_reg(sfot_pkg::ADDR_HWIDTH, sfot_pkg::RST_HWIDTH);
      rd_reg(sfot_pkg::ADDR_POL, sfot_pkg::RST_POL);
      rd_reg(sfot_pkg::ADDR_CLKMODE, sfot_pkg::RST_CLKMODE);
      wr_reg(8'h30, 8'h55);
      rd_reg(8'h30, 8'h00);
      wr_reg(sfot_pkg::ADDR_CLKMODE, 8'h73);
      rd_reg(sfot_pkg::ADDR_CLKMODE, 8'h70);
      wr_reg(sfot_pkg::ADDR_VDUR, 8'hA5);
      rd_reg(sfot_pkg::ADDR_VDUR, 8'hA5);
   endtask
   task automatic t_hsync;
      pulse_hs(9'h020);
      wr_reg(sfot_pkg::ADDR_HWIDTH, 8'h05);
      pulse_hs(9'h005);
      wr_reg(sfot_pkg::ADDR_POL, 8'h7E);
      hpol <= 1'b0;
      pulse_hs(9'h005);
      wr_reg(sfot_pkg::ADDR_HWIDTH, 8'h00);
      pulse_hs(9'h000);
      wr_reg(sfot_pkg::ADDR_POL, sfot_pkg::RST_POL);
      hpol <= 1'b1;
   endtask
   task automatic t_pol;
      logic [7:0] v;
      @(posedge clk_in);
      vs <= 1'b1;
      fld <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         v = (p == 0) ? 8'h0E : 8'hFE;
         wr_reg(sfot_pkg::ADDR_POL, v);
         cyc(4);
         #1;
         chk("vsync_out", vso, v[6]);
         chk("de_out", deo, !v[5]);
         chk("field_out", fo, v[4]);
      end
      @(posedge clk_in);
      vs <= 1'b0;
   endtask
   task automatic t_sog;
      logic [3:0] exp;
      exp = 4'b0101;
      @(posedge clk_in);
      sog_a <= 1'b1;
      hregen <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr_reg(sfot_pkg::ADDR_POL, 8'hF8 | 8'(c << 1));
         cyc(5);
         #1;
         chk("green_sync_out", sogo, exp[c]);
      end
      wr_reg(sfot_pkg::ADDR_POL, 8'hF0);
      cyc(5);
      #1;
      chk("green_sync_pol", sogo, 1'b0);
      // digital path must ignore the green sync polarity bit
      @(posedge clk_in);
      dig <= 1'b1;
      cyc(3);
      #1;
      chk("green_sync_digital", sogo, 1'b1);
      dig <= 1'b0;
      wr_reg(sfot_pkg::ADDR_POL, sfot_pkg::RST_POL);
      hregen <= 1'b0;
   endtask
   task automatic t_src;
      @(posedge clk_in);
      hs_a <= 1'b1;
      cyc(5);
      #1;
      chk("pll_filtered", pll_hs, 1'b0);
      chk("coast_regen", coast, 1'b0);
      wr_reg(sfot_pkg::ADDR_FILTER, 8'h0C);
      cyc(5);
      #1;
      chk("pll_raw", pll_hs, 1'b1);
      chk("coast_raw", coast, 1'b1);
      hs_a <= 1'b0;
   endtask
   task automatic t_vfilt;
      wr_reg(sfot_pkg::ADDR_FILTER, 8'hEC);
      vs <= 1'b1;
      hr_pulse;
      #1;
      chk("vsync_clipped", vso, 1'b0);
      hr_pulse;
      #1;
      chk("vsync_filtered", vso, 1'b1);
      vs <= 1'b0;
      hr_pulse;
      #1;
      chk("vsync_end", vso, 1'b0);
   endtask
   // restored vsync lasts two lines past the clipped start, then ends
   task automatic t_vdur;
      wr_reg(sfot_pkg::ADDR_VDUR, 8'h02);
      wr_reg(sfot_pkg::ADDR_FILTER, 8'hFC);
      vs <= 1'b1;
      hr_pulse;
      hr_pulse;
      #1;
      chk("vdur_start", vso, 1'b1);
      vs <= 1'b0;
      hr_pulse;
      #1;
      chk("vdur_restored", vso, 1'b1);
      hr_pulse;
      #1;
      chk("vdur_end", vso, 1'b0);
      wr_reg(sfot_pkg::ADDR_FILTER, sfot_pkg::RST_FILTER);
   endtask
   task automatic t_ofs;
      int fl, nl, fs, ns, f0, n0;
      ofs_run(8'hCC, fl, nl);
      ofs_run(8'hC8, fs, ns);
      ofs_run(8'hC4, f0, n0);
      chk("ofs_long_len", 24'(nl), 24'd6);
      chk("ofs_short_len", 24'(ns), 24'd6);
      chk("ofs_delay_step", 24'(fl - fs), 24'd6);
      chk("ofs_short_delay", 24'(fs - 4), 24'(sfot_pkg::OFS_DELAY_SHORT));
      chk("ofs_clamp_len", 24'(n0), 24'd3);
      wr_reg(sfot_pkg::ADDR_FILTER, sfot_pkg::RST_FILTER);
   endtask
   task automatic t_clk_data;
      logic cko_before;
      // eight enables later every rate repeats its phase, so only the invert bit differs
      cyc(1);
      #1;
      cko_before = cko;
      wr_reg(sfot_pkg::ADDR_POL, 8'hFF);
      cyc(6);
      #1;
      chk("clk_invert", cko, !cko_before);
      wr_reg(sfot_pkg::ADDR_POL, sfot_pkg::RST_POL);
      clk_run(sfot_pkg::CLK_SEL_HALF, 8'd4);
      clk_run(sfot_pkg::CLK_SEL_1X, 8'd8);
      clk_run(sfot_pkg::CLK_SEL_2X, 8'd16);
      clk_run(sfot_pkg::CLK_SEL_90, 8'd8);
      prep <= 2'h1;
      clk_run(sfot_pkg::CLK_SEL_1X, 8'd4);
      prep <= 2'h0;
      pix <= 24'hA5C3F0;
      cyc(3);
      #1;
      chk("data_out", dout, 24'hA5C3F0);
      chk("blue_ddr", {16'h0000, blue}, 24'h000000);
      wr_reg(sfot_pkg::ADDR_CLKMODE, 8'h74);
      cyc(3);
      #1;
      chk("data_422_y", {dout[23:16], dout[7:0]}, {pix[15:8], 8'h00});
      wr_reg(sfot_pkg::ADDR_CLKMODE, 8'h78);
      cyc(3);
      #1;
      chk("data_ddr_low", {12'h000, dout[11:0]}, 24'h000000);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      cyc(16);
      srst_in <= 1'b0;
      t_regs;
      t_hsync;
      t_pol;
      t_sog;
      t_src;
      t_vfilt;
      t_vdur;
      t_ofs;
      t_clk_data;
      stop_test;
   end
   // the whole run needs well under 2000 cycles
   initial begin
      cyc(20000);
      bad_count++;
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
